// *** logic/ssp_pin_if.sv ***
// interface: drive request of one port toward the pin stage
`timescale 1ns/10ps
interface ssp_pin_if;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    modport src (output out, output oe);
    modport stage (input out, input oe, output pin_out, output pin_oe);
endinterface

// *** logic/ssp_pin_stage.sv ***
// module: per-port pin stage with mode dependent hold and high impedance
`timescale 1ns/10ps
module ssp_pin_stage
    import ssp_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // mode
    input wire ssp_pkg::ssp_mode_t mode,
    // pins
    ssp_pin_if.stage pins
);
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } ssp_stage_t;

    ssp_stage_t st_q;
    ssp_stage_t st_d;

    always_comb begin
        st_d = st_q;
        unique case (mode)
            SSP_MODE_ACTIVE, SSP_MODE_SUBACT: begin
                st_d.out = pins.out;
                st_d.oe = pins.oe;
            end
            SSP_MODE_RETAIN: begin
                st_d = st_q;
            end
            SSP_MODE_HIZ: begin
                st_d.oe = 8'h00;
            end
            default: begin
                st_d.oe = 8'h00;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // live in functional modes, held in retain, released in standby/reset
    assign pins.pin_out = (mode == SSP_MODE_RETAIN) ? st_q.out : pins.out;
    assign pins.pin_oe = !hresetn ? 8'h00 :
                         (mode == SSP_MODE_RETAIN) ? st_q.oe :
                         (mode == SSP_MODE_HIZ) ? 8'h00 :
                         ((mode == SSP_MODE_ACTIVE) || (mode == SSP_MODE_SUBACT)) ? pins.oe :
                         8'h00;
endmodule

// *** logic/ssp_pkg.sv ***
// package: register map, field layout, reset values and mode codes
package ssp_pkg;
    // register offsets are word indices, byte address is four times the index
    localparam logic [31:0] SSP_P8_LATCH_OFS = 32'h0000_ffdb;
    localparam logic [31:0] SSP_P9_LATCH_OFS = 32'h0000_ffdc;
    localparam logic [31:0] SSP_P8_DIR_OFS = 32'h0000_ffeb;
    localparam logic [31:0] SSP_P9_DIR_OFS = 32'h0000_ffec;
    localparam logic [7:0] SSP_LATCH_RST = 8'h00;
    localparam logic [7:0] SSP_DIR_RST = 8'h00;
    localparam logic [7:0] SSP_DIR_READ = 8'hff;
    localparam logic [3:0] SSP_SEL_GPIO = 4'h0;
    localparam int SSP_SEL_P8_LSB = 1;
    localparam logic [2:0] SSP_SEL_P8_GPIO = 3'h0;
    localparam int SSP_P9_UPPER_LSB = 4;
    localparam int SSP_SEG_P8_BASE = 25;
    localparam int SSP_SEG_P9_BASE = 33;
    typedef enum logic [3:0] {
        SSP_MODE_ACTIVE = 4'b0001,
        SSP_MODE_RETAIN = 4'b0010,
        SSP_MODE_HIZ = 4'b0100,
        SSP_MODE_SUBACT = 4'b1000
    } ssp_mode_t;
endpackage

// *** logic/ssp_segment_shared_io_ports.sv ***
// module: two gpio ports shared with lcd segment and expander outputs
`timescale 1ns/10ps
module ssp_segment_shared_io_ports
    import ssp_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // system and lcd controller
    input wire ssp_pkg::ssp_mode_t mode,
    input wire logic [3:0] panel_drive_select,
    input wire logic expander_enable_bit,
    input wire logic [7:0] seg_p8,
    input wire logic [7:0] seg_p9,
    input wire logic expander_latch_pulse,
    input wire logic expander_shift_pulse,
    input wire logic expander_data,
    input wire logic expander_alternation,
    // port 8 pins
    input wire logic [7:0] p8_in,
    output logic [7:0] p8_out,
    output logic [7:0] p8_oe,
    // port 9 pins
    input wire logic [7:0] p9_in,
    output logic [7:0] p9_out,
    output logic [7:0] p9_oe
);
    typedef struct packed {
        logic [7:0] p8_latch;
        logic [7:0] p8_dir;
        logic [7:0] p9_latch;
        logic [7:0] p9_dir;
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
    } ssp_regs_t;

    ssp_regs_t r_q;
    ssp_regs_t r_d;
    logic addr_phase;
    logic [31:0] rd_val;
    logic p8_gpio;
    logic p9_gpio;
    logic [7:0] p8_rd;
    logic [7:0] p9_rd;
    logic [7:0] p9_func_out;
    logic [7:0] p9_func_oe;
    logic [3:0] expander_bus;

    ssp_pin_if p8_if ();
    ssp_pin_if p9_if ();

    ////////////////////////////////////////////////////////////////////////////
    // pin function select

    assign p8_gpio = (panel_drive_select[3:SSP_SEL_P8_LSB] == SSP_SEL_P8_GPIO);
    assign p9_gpio = (panel_drive_select == SSP_SEL_GPIO);
    assign expander_bus = {expander_latch_pulse, expander_shift_pulse,
                           expander_data, expander_alternation};

    // port 8: gpio under direction bits, else segment lines 25..32
    assign p8_if.out = p8_gpio ? r_q.p8_latch : seg_p8;
    assign p8_if.oe = p8_gpio ? r_q.p8_dir : 8'hff;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_p9
            if (gi >= SSP_P9_UPPER_LSB) begin : g_up
                always_comb begin
                    if (expander_enable_bit) begin
                        p9_func_out[gi] = expander_bus[gi - SSP_P9_UPPER_LSB];
                        p9_func_oe[gi] = 1'b1;
                    end else if (p9_gpio) begin
                        p9_func_out[gi] = r_q.p9_latch[gi];
                        p9_func_oe[gi] = r_q.p9_dir[gi];
                    end else begin
                        p9_func_out[gi] = seg_p9[gi];
                        p9_func_oe[gi] = 1'b1;
                    end
                end
            end else begin : g_lo
                always_comb begin
                    if (p9_gpio) begin
                        p9_func_out[gi] = r_q.p9_latch[gi];
                        p9_func_oe[gi] = r_q.p9_dir[gi];
                    end else begin
                        p9_func_out[gi] = seg_p9[gi];
                        p9_func_oe[gi] = 1'b1;
                    end
                end
            end
        end
    endgenerate

    assign p9_if.out = p9_func_out;
    assign p9_if.oe = p9_func_oe;

    ////////////////////////////////////////////////////////////////////////////
    // pin stages

    ssp_pin_stage u_p8_stage (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(mode),
        .pins(p8_if.stage)
    );

    ssp_pin_stage u_p9_stage (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(mode),
        .pins(p9_if.stage)
    );

    assign p8_out = p8_if.pin_out;
    assign p8_oe = p8_if.pin_oe;
    assign p9_out = p9_if.pin_out;
    assign p9_oe = p9_if.pin_oe;

    ////////////////////////////////////////////////////////////////////////////
    // register read values

    assign p8_rd = (r_q.p8_dir & r_q.p8_latch) | (~r_q.p8_dir & p8_in);
    assign p9_rd = (r_q.p9_dir & r_q.p9_latch) | (~r_q.p9_dir & p9_in);

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case ({2'b00, haddr[31:2]})
            SSP_P8_LATCH_OFS: rd_val = {24'h00_0000, p8_rd};
            SSP_P9_LATCH_OFS: rd_val = {24'h00_0000, p9_rd};
            SSP_P8_DIR_OFS: rd_val = {24'h00_0000, SSP_DIR_READ};
            SSP_P9_DIR_OFS: rd_val = {24'h00_0000, SSP_DIR_READ};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states

    assign addr_phase = hsel && hready && htrans[1];

    always_comb begin
        r_d = r_q;
        r_d.wr_pend = 1'b0;
        if (r_q.wr_pend) begin
            unique case (r_q.wr_addr)
                SSP_P8_LATCH_OFS: r_d.p8_latch = hwdata[7:0];
                SSP_P9_LATCH_OFS: r_d.p9_latch = hwdata[7:0];
                SSP_P8_DIR_OFS: r_d.p8_dir = hwdata[7:0];
                SSP_P9_DIR_OFS: r_d.p9_dir = hwdata[7:0];
                default: r_d.p9_dir = r_q.p9_dir;
            endcase
        end
        if (addr_phase) begin
            r_d.wr_pend = hwrite;
            r_d.wr_addr = {2'b00, haddr[31:2]};
            if (!hwrite) begin
                r_d.rdata = rd_val;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_q.p8_latch <= SSP_LATCH_RST;
            r_q.p8_dir <= SSP_DIR_RST;
            r_q.p9_latch <= SSP_LATCH_RST;
            r_q.p9_dir <= SSP_DIR_RST;
            r_q.wr_pend <= 1'b0;
            r_q.wr_addr <= 32'h0000_0000;
            r_q.rdata <= 32'h0000_0000;
        end else begin
            r_q <= r_d;
        end
    end

    assign hrdata = r_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

// *** testbench/ssp_io_assertions.sv ***
// checker: pin drive and read data properties at the top ports
`timescale 1ns/10ps
module ssp_chk
    import ssp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire ssp_pkg::ssp_mode_t mode,
    input wire logic [3:0] panel_drive_select,
    input wire logic expander_enable_bit,
    input wire logic [7:0] seg_p8,
    input wire logic [7:0] seg_p9,
    input wire logic expander_latch_pulse,
    input wire logic expander_data,
    input wire logic [7:0] p8_in,
    input wire logic [7:0] p9_in,
    input wire logic [7:0] p8_out,
    input wire logic [7:0] p8_oe,
    input wire logic [7:0] p9_out,
    input wire logic [7:0] p9_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic rd = hsel && hready && htrans[1] && !hwrite;
    wire logic act = mode == SSP_MODE_ACTIVE;
    p8_segment_a: assert property (act && panel_drive_select[3:1] != 3'h0
        |-> p8_out == seg_p8 && p8_oe == 8'hff) else $error("port 8 segment drive");
    p9_segment_a: assert property (act && panel_drive_select != 4'h0
        && !expander_enable_bit |-> p9_out == seg_p9 && p9_oe == 8'hff)
        else $error("port 9 segment drive");
    expander_pins_a: assert property (act && expander_enable_bit |-> p9_oe[7:4] == 4'hf
        && p9_out[7] == expander_latch_pulse && p9_out[5] == expander_data)
        else $error("expander drive");
    standby_hiz_a: assert property (mode == SSP_MODE_HIZ |-> (p8_oe | p9_oe) == 8'h00)
        else $error("standby pins driven");
    retain_hold_a: assert property ($past(hresetn) && mode == SSP_MODE_RETAIN
        && $past(mode) == SSP_MODE_RETAIN |-> $stable(p9_out) && $stable(p9_oe)
        && $stable(p8_out) && $stable(p8_oe)) else $error("retained pins moved");
    dir_read_a: assert property (rd && (haddr[31:2] == SSP_P9_DIR_OFS[29:0] ||
        haddr[31:2] == SSP_P8_DIR_OFS[29:0]) |=> hrdata == 32'h0000_00ff)
        else $error("direction read");
    p9_read_a: assert property (rd && act && haddr[31:2] == SSP_P9_LATCH_OFS[29:0] &&
        panel_drive_select == 4'h0 && !expander_enable_bit |=> hrdata[7:0] ==
        $past(p9_oe & p9_out | ~p9_oe & p9_in)) else $error("port 9 read");
    p8_read_a: assert property (rd && act && haddr[31:2] == SSP_P8_LATCH_OFS[29:0] &&
        panel_drive_select[3:1] == 3'h0 |=> hrdata[7:0] ==
        $past(p8_oe & p8_out | ~p8_oe & p8_in)) else $error("port 8 read");
endmodule
bind ssp_segment_shared_io_ports ssp_chk ssp_chk_i (.*);

// *** testbench/ssp_pin_model.sv ***
// model: level seen on the shared pins from both sides
`timescale 1ns/10ps
module ssp_pin_model (
    // drive from the port
    input wire logic [7:0] out,
    input wire logic [7:0] oe,
    // far side drive, changes every cycle
    input wire logic [7:0] ext,
    output logic [7:0] lvl
);
    assign lvl = oe & out | ~oe & ext;
endmodule

// *** testbench/ssp_segment_shared_io_ports_test.sv ***
// testbench: register access, pin selection and mode handling
`timescale 1ns/10ps
module ssp_segment_shared_io_ports_test;
    import ssp_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, expander_enable_bit = 0;
    wire logic hready;
    logic expander_latch_pulse = 0, expander_shift_pulse = 0, expander_data = 0;
    logic expander_alternation = 0, hreadyout, hresp, rdp = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] panel_drive_select = 0;
    logic [7:0] seg_p8 = 0, seg_p9 = 0, ext8 = 0, ext9 = 0, p8_in, p9_in;
    logic [7:0] p8_out, p8_oe, p9_out, p9_oe, exq[$], sh[5] = '{default: 0};
    logic [31:0] haddr = 0, hwdata = 0, hrdata, lfsr = 32'h8462_578f;
    logic [31:0] adr[5] = '{{SSP_P8_LATCH_OFS[29:0], 2'b00}, {SSP_P9_LATCH_OFS[29:0], 2'b00},
        {SSP_P8_DIR_OFS[29:0], 2'b00}, {SSP_P9_DIR_OFS[29:0], 2'b00}, 32'h0000_ffe0};
    ssp_mode_t mode = SSP_MODE_ACTIVE;
    int miscompares = 0, samples_checked = 0;
    assign hready = hreadyout;
    ssp_segment_shared_io_ports ssp_segment_shared_io_ports_i (.*);
    ssp_pin_model pm8_i (.out(p8_out), .oe(p8_oe), .ext(ext8), .lvl(p8_in));
    ssp_pin_model pm9_i (.out(p9_out), .oe(p9_oe), .ext(ext9), .lvl(p9_in));
    initial forever #4 hclk = ~hclk;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    always @(posedge hclk) begin
        lfsr <= nxt(lfsr);
        {seg_p9, seg_p8, ext9, ext8} <= lfsr;
        {expander_latch_pulse, expander_shift_pulse, expander_data, expander_alternation}
            <= lfsr[5:2];
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input int r, input logic wr, input logic [7:0] wd);
        logic [7:0] e;
        htrans <= 2'h2;
        haddr <= adr[r];
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        e = r == 4 ? 8'h00 : r > 1 ? 8'hff : sh[r+2] & sh[r] | ~sh[r+2] & (r ? ext9 : ext8);
        if (!wr) exq.push_back(e);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        if (wr) sh[r] = wd;
    endtask
    always @(posedge hclk) begin
        if (rdp) chk("read data", hrdata, {24'h0, exq.pop_front()});
        if (rdp) chk("response", {hreadyout, hresp}, 2'b10);
        rdp <= htrans[1] & ~hwrite & hreadyout;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        logic [63:0] f;
        logic [15:0] o9;
        repeat (8) @(posedge hclk);
        #1 chk("reset oe", {p8_oe, p9_oe}, 0);
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        for (int i = 0; i < 60; i++) xfer(int'(lfsr % 5), lfsr[7], lfsr[15:8]);
        #1 chk("gpio pins", {p8_out, p8_oe, p9_out, p9_oe}, {sh[0], sh[2], sh[1], sh[3]});
        for (int s = 0; s < 32; s++) begin
            @(posedge hclk);
            panel_drive_select <= s[3:0];
            expander_enable_bit <= s[4];
            #1;
            o9 = s[3:0] ? {seg_p9, 8'hff} : {sh[1], sh[3]};
            if (s[4]) o9[15:12] = {expander_latch_pulse, expander_shift_pulse,
                expander_data, expander_alternation};
            if (s[4]) o9[7:4] = 4'hf;
            chk("port 8 pins", {p8_out, p8_oe}, s[3:1] ? {seg_p8, 8'hff} : {sh[0], sh[2]});
            chk("port 9 pins", {p9_out, p9_oe}, o9);
        end
        @(posedge hclk);
        panel_drive_select <= 4'h3;
        expander_enable_bit <= 0;
        @(posedge hclk);
        f = {seg_p8, 8'hff, seg_p9, 8'hff};
        mode <= SSP_MODE_RETAIN;
        xfer(1, 1, 8'h5a);
        #1 chk("held pins", {p8_out, p8_oe, p9_out, p9_oe}, f);
        @(posedge hclk);
        mode <= SSP_MODE_HIZ;
        #1 chk("standby oe", {p8_oe, p9_oe}, 0);
        @(posedge hclk);
        mode <= SSP_MODE_SUBACT;
        #1 chk("subactive pins", {p8_out, p8_oe}, {seg_p8, 8'hff});
        repeat (3) @(posedge hclk);
        tally_and_finish();
    end
endmodule
